// File: epid_avalon_slave.sv
// Avalon-MM slave front end: one wait cycle, then a single response cycle
// Assumes master holds the request until waitrequest is sampled low
`timescale 1ns/1ps
`include "epid_defs.svh"
module epid_avalon_slave (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Bus
  input wire logic i_read,
  input wire logic i_write,
  // Access strobes
  output logic o_accept,
  output logic o_wait
);
  import epid_pkg::*;
  epid_bus_state_t state_q;
  epid_bus_state_t state_d;

  // Handshake sequencing
  always_comb
  begin
    case (state_q)
      EPID_IDLE: state_d = (i_read | i_write) ? EPID_RESP : EPID_IDLE;
      EPID_RESP: state_d = EPID_DONE;
      EPID_DONE: state_d = EPID_IDLE;
      default: state_d = EPID_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      state_q <= EPID_IDLE;
    else
      state_q <= state_d;
  end

  // Accept in the response cycle while requested, wait in every other cycle
  assign o_accept = (state_q == EPID_RESP) & (i_read | i_write);
  assign o_wait = ~o_accept;
endmodule : epid_avalon_slave

// File: epid_defs.svh
// Constants for the external pin interrupt detector
// Assumes inclusion by bare name from the package and modules
//
// Summary of operation
// - Pin acts as interrupt input only while enable bit 4 is set.
// - Enabled pin gets an internal pull unless pull is disabled.
// - Bit 6 read/write pull disable; one turns internal pull off.
// - Rising polarity turns the internal pull into a pulldown.
// - Polarity bit: zero falling or low, one rising or high.
// - Mode bit 0: zero edges only, one edges plus asserted level.
// - Read-only event flag bit 3 sets on each qualifying event.
// - Writing one to acknowledge bit 2 clears the event flag.
// - Writing zero to acknowledge does nothing; it always reads zero.
// - In level mode flag stays set while pin holds asserted level.
// - Interrupt request while flag and enable bit 1 are both one.
`ifndef EPID_DEFS_SVH
`define EPID_DEFS_SVH
`define EPID_OFS_CTRL 4'h0
`define EPID_OFS_IRQ_STATUS 4'h4
`define EPID_OFS_IRQ_MASK 4'h8
`define EPID_BIT_MODE 0
`define EPID_BIT_IE 1
`define EPID_BIT_ACK 2
`define EPID_BIT_FLAG 3
`define EPID_BIT_PE 4
`define EPID_BIT_POL 5
`define EPID_BIT_PDD 6
`define EPID_CTRL_RESET 8'h00
`define EPID_CTRL_FIELDS_RESET 5'h00
`define EPID_BIT_STATUS_EVENT 0
`define EPID_MASK_RESET 1'b0
`define EPID_UNMAPPED_DATA 32'hdeadbeef
`endif

// File: epid_det_if.sv
// Interface carrying configuration and events between detector parts
// Assumes both ends use the same system clock
`timescale 1ns/1ps
interface epid_det_if;
  import epid_pkg::*;
  epid_ctrl_t ctrl;
  logic edge_event;
  logic level_asserted;
  modport source (input ctrl, output edge_event, output level_asserted);
  modport sink (output ctrl, input edge_event, input level_asserted);
endinterface : epid_det_if

// File: epid_irq_source.sv
// External interrupt source model driving the detector pin
// Assumes the bench steers it on the rising clock edge; pull enables come from the device
`timescale 1ns/1ps
module epid_irq_source (
  // Clock
  input wire logic i_clk,
  // Control from the bench
  input wire logic i_drive,
  input wire logic i_level,
  input wire logic i_slow,
  // Pull controls from the device
  input wire logic i_pullup_en,
  input wire logic i_pulldown_en,
  // Pin
  output logic o_pin
);
  logic [3:0] level_q = 4'h0;
  logic toggle_q = 1'b0;

  // Level history gives a prompt or a slow answer
  always_ff @(posedge i_clk)
  begin
    level_q <= {level_q[2:0], i_level};
    toggle_q <= ~toggle_q;
  end

  // Released pin follows the pull, or wanders when nothing holds it
  assign o_pin = i_drive ? (i_slow ? level_q[3] : level_q[0]) :
                 i_pullup_en ? 1'b1 : i_pulldown_en ? 1'b0 : toggle_q;
endmodule : epid_irq_source

// File: epid_pin_sense.sv
// Pin synchroniser and polarity-aware edge and level detection
// Assumes the pin is an asynchronous external level
`timescale 1ns/1ps
`include "epid_defs.svh"
module epid_pin_sense (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Raw pin
  input wire logic i_pin,
  // Detector link
  epid_det_if.source det
);
  import epid_pkg::*;
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;
  logic prev_q;
  logic prev_d;
  logic asserted;
  logic prev_asserted;

  // Next values of synchroniser and history
  // two stage synchroniser
  always_comb
  begin
    meta_d = i_pin;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  // Registers; reset to idle high so no false falling edge
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  assign asserted = det.ctrl.polarity_select ? sync_q : ~sync_q;
  assign prev_asserted = det.ctrl.polarity_select ? prev_q : ~prev_q;
  assign det.edge_event = det.ctrl.pin_function_enable & asserted & ~prev_asserted;
  assign det.level_asserted = det.ctrl.pin_function_enable & asserted;

  a_edge_needs_change: assert property (@(posedge i_clk) disable iff (i_rst)
    det.edge_event |-> (sync_q != prev_q)) else $error("edge without pin change");
endmodule : epid_pin_sense

// File: epid_pkg.sv
// Types shared by the pin interrupt detector modules
// Assumes the constants header is available
`include "epid_defs.svh"
package epid_pkg;
  // Bus slave handshake states
  typedef enum logic [2:0] {
    EPID_IDLE = 3'b001,
    EPID_RESP = 3'b010,
    EPID_DONE = 3'b100
  } epid_bus_state_t;
  // Control register fields
  typedef struct packed {
    logic pull_disable;
    logic polarity_select;
    logic pin_function_enable;
    logic detection_mode;
    logic event_interrupt_enable;
  } epid_ctrl_t;
endpackage : epid_pkg

// File: epid_top.sv
// External pin interrupt detector with Avalon-MM register access
// Assumes a synchronous Avalon master and an external interrupt source pin
`timescale 1ns/1ps
`include "epid_defs.svh"
module epid_top (
  // Clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_SYS_RST,
  // Avalon-MM slave
  input wire logic [3:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  // Interrupt pin and pull control
  input wire logic I_IRQ_PIN,
  output logic O_PULLUP_EN,
  output logic O_PULLDOWN_EN,
  // Interrupt outputs
  output logic O_HW_IRQ,
  output logic O_IRQ
);
  import epid_pkg::*;
  epid_det_if det ();
  logic accept;
  logic wait_raw;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;
  logic ack_wr;
  epid_ctrl_t ctrl_q;
  epid_ctrl_t ctrl_d;
  logic flag_q;
  logic flag_d;
  logic status_q;
  logic status_d;
  logic mask_q;
  logic mask_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic wait_q;
  logic hw_irq_q;
  logic irq_q;
  logic pu_q;
  logic pd_q;
  logic wait_d;
  logic hw_irq_d;
  logic irq_d;
  logic pu_d;
  logic pd_d;
  logic [7:0] ctrl_view;

  epid_avalon_slave u_bus (
    .i_clk(I_CLK_SYS),
    .i_rst(I_SYS_RST),
    .i_read(I_AVS_READ),
    .i_write(I_AVS_WRITE),
    .o_accept(accept),
    .o_wait(wait_raw)
  );

  epid_pin_sense u_sense (
    .i_clk(I_CLK_SYS),
    .i_rst(I_SYS_RST),
    .i_pin(I_IRQ_PIN),
    .det(det)
  );

  assign det.ctrl = ctrl_q;

  // Write strobes, low byte lane only
  assign wr_ctrl = accept & I_AVS_WRITE & I_AVS_BYTEENABLE[0] & (I_AVS_ADDRESS == `EPID_OFS_CTRL);
  assign wr_stat = accept & I_AVS_WRITE & I_AVS_BYTEENABLE[0] & (I_AVS_ADDRESS == `EPID_OFS_IRQ_STATUS);
  assign wr_mask = accept & I_AVS_WRITE & I_AVS_BYTEENABLE[0] & (I_AVS_ADDRESS == `EPID_OFS_IRQ_MASK);
  assign ack_wr = wr_ctrl & I_AVS_WRITEDATA[`EPID_BIT_ACK];

  // Control register read view; acknowledge reads zero
  // acknowledge reads zero
  always_comb
  begin
    ctrl_view = 8'h00;
    ctrl_view[`EPID_BIT_PDD] = ctrl_q.pull_disable;
    ctrl_view[`EPID_BIT_POL] = ctrl_q.polarity_select;
    ctrl_view[`EPID_BIT_PE] = ctrl_q.pin_function_enable;
    ctrl_view[`EPID_BIT_FLAG] = flag_q;
    ctrl_view[`EPID_BIT_IE] = ctrl_q.event_interrupt_enable;
    ctrl_view[`EPID_BIT_MODE] = ctrl_q.detection_mode;
  end

  // Control register group: next value on a lane 0 write
  always_comb
  begin
    ctrl_d = ctrl_q;
    if (wr_ctrl)
    begin
      ctrl_d.pull_disable = I_AVS_WRITEDATA[`EPID_BIT_PDD];
      ctrl_d.polarity_select = I_AVS_WRITEDATA[`EPID_BIT_POL];
      ctrl_d.pin_function_enable = I_AVS_WRITEDATA[`EPID_BIT_PE];
      ctrl_d.event_interrupt_enable = I_AVS_WRITEDATA[`EPID_BIT_IE];
      ctrl_d.detection_mode = I_AVS_WRITEDATA[`EPID_BIT_MODE];
    end
  end

  // Control register group: storage
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
      ctrl_q <= epid_ctrl_t'(`EPID_CTRL_FIELDS_RESET);
    else
      ctrl_q <= ctrl_d;
  end

  // Event flag group: a new event wins over a same-cycle acknowledge
  always_comb
  begin
    flag_d = flag_q;
    if (ack_wr)
      flag_d = 1'b0;
    if (ctrl_q.detection_mode & det.level_asserted)
      flag_d = 1'b1;
    // edge sets flag, wins over clear
    if (det.edge_event)
      flag_d = 1'b1;
  end

  // Event flag group: storage
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
      flag_q <= 1'b0;
    else
      flag_q <= flag_d;
  end

  // Sticky status and mask group: next values
  always_comb
  begin
    status_d = status_q;
    mask_d = mask_q;
    // Write one clears, a new event wins
    if (wr_stat & I_AVS_WRITEDATA[`EPID_BIT_STATUS_EVENT])
      status_d = 1'b0;
    if (det.edge_event | (ctrl_q.detection_mode & det.level_asserted))
      status_d = 1'b1;
    if (wr_mask)
      mask_d = I_AVS_WRITEDATA[`EPID_BIT_STATUS_EVENT];
  end

  // Sticky status and mask group: storage
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      status_q <= 1'b0;
      mask_q <= `EPID_MASK_RESET;
    end
    else
    begin
      status_q <= status_d;
      mask_q <= mask_d;
    end
  end

  // Read data group: loaded in the response cycle, held until the next read
  always_comb
  begin
    rdata_d = rdata_q;
    if (accept & I_AVS_READ)
    begin
      case (I_AVS_ADDRESS)
        `EPID_OFS_CTRL: rdata_d = {24'h000000, ctrl_view};
        `EPID_OFS_IRQ_STATUS: rdata_d = {31'h0, status_q};
        `EPID_OFS_IRQ_MASK: rdata_d = {31'h0, mask_q};
        default: rdata_d = `EPID_UNMAPPED_DATA;
      endcase
    end
  end

  // Read data group: storage
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
      rdata_q <= 32'h00000000;
    else
      rdata_q <= rdata_d;
  end

  // Output group: next values come from the next state, so each output flop except waitrequest
  // changes on the same edge as the state that it mirrors; waitrequest follows the current accept, one cycle later
  always_comb
  begin
    // Waitrequest low only in the cycle after the slave's response cycle
    wait_d = wait_raw;
    hw_irq_d = flag_d & ctrl_d.event_interrupt_enable;
    irq_d = status_d & mask_d;
    pu_d = ctrl_d.pin_function_enable & ~ctrl_d.pull_disable & ~ctrl_d.polarity_select;
    pd_d = ctrl_d.pin_function_enable & ~ctrl_d.pull_disable & ctrl_d.polarity_select;
  end

  // Output group: storage; waitrequest resets high so nothing is answered early
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      wait_q <= 1'b1;
      hw_irq_q <= 1'b0;
      irq_q <= 1'b0;
      pu_q <= 1'b0;
      pd_q <= 1'b0;
    end
    else
    begin
      wait_q <= wait_d;
      hw_irq_q <= hw_irq_d;
      irq_q <= irq_d;
      pu_q <= pu_d;
      pd_q <= pd_d;
    end
  end

  // Every top-level output comes straight from its flip-flop
  assign O_AVS_READDATA = rdata_q;
  assign O_AVS_WAITREQUEST = wait_q;
  assign O_HW_IRQ = hw_irq_q;
  assign O_IRQ = irq_q;
  assign O_PULLUP_EN = pu_q;
  assign O_PULLDOWN_EN = pd_q;

  a_edge_sets_flag: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    det.edge_event |=> flag_q) else $error("edge did not set flag");
  a_ack_clears_flag: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    ack_wr & ~det.edge_event & ~(ctrl_q.detection_mode & det.level_asserted) |=> ~flag_q)
    else $error("ack did not clear flag");
  a_level_holds_flag: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    ctrl_q.detection_mode & det.level_asserted |=> flag_q) else $error("flag cleared under level");
  a_hw_irq_tracks: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    ##1 (O_HW_IRQ == (flag_q & ctrl_q.event_interrupt_enable))) else $error("irq request mismatch");
  a_pull_polarity: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    O_PULLDOWN_EN |-> ctrl_q.polarity_select && !O_PULLUP_EN) else $error("pull polarity wrong");
  a_pull_disable: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    ctrl_q.pull_disable |-> !O_PULLUP_EN && !O_PULLDOWN_EN) else $error("pull on while disabled");
  a_pull_enabled: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    ctrl_q.pin_function_enable & ~ctrl_q.pull_disable |-> O_PULLUP_EN | O_PULLDOWN_EN) else $error("pull missing");
  a_disabled_quiet: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    !ctrl_q.pin_function_enable |-> !det.edge_event && !det.level_asserted) else $error("disabled pin active");
  a_ack_reads_zero: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    accept & I_AVS_READ & (I_AVS_ADDRESS == `EPID_OFS_CTRL) |=> !O_AVS_READDATA[`EPID_BIT_ACK]) else $error("ack read one");
  a_enable_write_one: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    wr_ctrl & I_AVS_WRITEDATA[`EPID_BIT_PE] |=> ctrl_q.pin_function_enable) else $error("enable not stored");
  a_enable_write_zero: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    wr_ctrl & !I_AVS_WRITEDATA[`EPID_BIT_PE] |=> !ctrl_q.pin_function_enable) else $error("enable not cleared");
  a_polarity_write: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    wr_ctrl & I_AVS_WRITEDATA[`EPID_BIT_POL] |=> ctrl_q.polarity_select) else $error("polarity not stored");
  a_mode_write: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    wr_ctrl & I_AVS_WRITEDATA[`EPID_BIT_MODE] |=> ctrl_q.detection_mode) else $error("mode not stored");
  a_edge_mode_clear: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    ack_wr & !ctrl_q.detection_mode & !det.edge_event |=> !flag_q) else $error("level held flag in edge mode");
  a_ack_zero_keeps: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    wr_ctrl & !I_AVS_WRITEDATA[`EPID_BIT_ACK] & flag_q |=> flag_q) else $error("zero ack cleared flag");
  a_flag_needs_cause: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    $rose(flag_q) |-> $past(det.edge_event) | $past(det.level_asserted)) else $error("flag set without event");
  // Sticky status set by an edge
  a_status_sets: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    det.edge_event |=> status_q) else $error("edge did not set status");
  // Sticky status cleared by a written one
  a_status_clears: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    wr_stat & I_AVS_WRITEDATA[`EPID_BIT_STATUS_EVENT] & !det.edge_event
    & !(ctrl_q.detection_mode & det.level_asserted) |=> !status_q) else $error("status not cleared");
  // Waitrequest answers the cycle after acceptance
  a_wait_after_accept: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    accept |=> !O_AVS_WAITREQUEST) else $error("no answer after accept");
  // Waitrequest low for one cycle only
  a_wait_one_cycle: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    !O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST) else $error("waitrequest low too long");
  // Unmapped read returns the filler word
  a_unmapped_read: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    accept & I_AVS_READ & (I_AVS_ADDRESS != `EPID_OFS_CTRL) & (I_AVS_ADDRESS != `EPID_OFS_IRQ_STATUS)
    & (I_AVS_ADDRESS != `EPID_OFS_IRQ_MASK) |=> (O_AVS_READDATA == `EPID_UNMAPPED_DATA))
    else $error("unmapped read data wrong");
endmodule : epid_top

// File: epid_top_tb.sv
// Self-checking bench for the external pin interrupt detector
// Assumes the design files and the source model are compiled first
`timescale 1ns/1ps
`include "epid_defs.svh"
module epid_top_tb;
  import epid_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'hf;
  logic [31:0] rdata;
  logic wait_req, pin, pu, pd, hw_irq, irq;
  logic drv = 1'b0;
  logic lvl = 1'b1;
  logic slow = 1'b0;
  logic [31:0] got;
  logic [31:0] cfg;
  logic [31:0] ack = 32'h1 << `EPID_BIT_ACK;
  logic [31:0] flg = 32'h1 << `EPID_BIT_FLAG;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;

  // Clock
  initial forever #5 clk = ~clk;

  epid_top dut_u (
    .I_CLK_SYS(clk), .I_SYS_RST(rst), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd), .I_AVS_WRITE(wr),
    .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(be), .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wait_req),
    .I_IRQ_PIN(pin), .O_PULLUP_EN(pu), .O_PULLDOWN_EN(pd), .O_HW_IRQ(hw_irq), .O_IRQ(irq)
  );

  epid_irq_source src_u (
    .i_clk(clk), .i_drive(drv), .i_level(lvl), .i_slow(slow),
    .i_pullup_en(pu), .i_pulldown_en(pd), .o_pin(pin)
  );

  // Verdict and end of run
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask : chk

  // One bus access, held until waitrequest is sampled low
  task automatic avs(input logic is_rd, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    rd <= is_rd;
    wr <= ~is_rd;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    while (wait_req !== 1'b0) @(posedge clk);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : avs

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    avs(1'b0, a, d, got);
  endtask : wr_reg

  task automatic chk_reg(input string nm, input logic [3:0] a, input logic [31:0] e);
    avs(1'b1, a, 32'h0, got);
    chk(nm, e, got);
  endtask : chk_reg

  task automatic settle();
    repeat (10) @(posedge clk);
  endtask : settle

  task automatic set_pin(input logic v);
    lvl <= v;
    settle();
  endtask : set_pin

  function automatic logic [31:0] ctl(input int md, ie, pe, pol, pdd);
    return {25'h0, pdd[0], pol[0], pe[0], 2'b00, ie[0], md[0]};
  endfunction : ctl

  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    chk("wait idle", 32'h1, {31'h0, wait_req});
    chk_reg("ctrl reset", `EPID_OFS_CTRL, {24'h0, `EPID_CTRL_RESET});
    chk_reg("status reset", `EPID_OFS_IRQ_STATUS, 32'h0);
    chk_reg("mask reset", `EPID_OFS_IRQ_MASK, 32'h0);
    chk("pulls disabled", 32'h0, {30'h0, pu, pd});
    settle();
    chk_reg("flag while disabled", `EPID_OFS_CTRL, 32'h0);
    drv <= 1'b1;
    wr_reg(`EPID_OFS_CTRL, ctl(0, 0, 1, 0, 0));
    settle();
    chk("pullup", 32'h2, {30'h0, pu, pd});
    wr_reg(`EPID_OFS_CTRL, ctl(0, 0, 1, 0, 1));
    settle();
    chk("pull off", 32'h0, {30'h0, pu, pd});
    wr_reg(`EPID_OFS_CTRL, ctl(0, 0, 1, 1, 0));
    settle();
    chk("pulldown", 32'h1, {30'h0, pu, pd});
    cfg = ctl(0, 0, 1, 0, 0);
    wr_reg(`EPID_OFS_CTRL, cfg | ack);
    set_pin(1'b0);
    chk_reg("falling flag", `EPID_OFS_CTRL, cfg | flg);
    chk("irq disabled", 32'h0, {31'h0, hw_irq});
    cfg = ctl(0, 1, 1, 0, 0);
    wr_reg(`EPID_OFS_CTRL, cfg);
    settle();
    chk("irq enabled", 32'h1, {31'h0, hw_irq});
    chk_reg("ack zero", `EPID_OFS_CTRL, cfg | flg);
    wr_reg(`EPID_OFS_CTRL, cfg | ack);
    chk_reg("ack one", `EPID_OFS_CTRL, cfg);
    chk("irq after ack", 32'h0, {31'h0, hw_irq});
    slow <= 1'b1;
    set_pin(1'b1);
    chk_reg("rising ignored", `EPID_OFS_CTRL, cfg);
    cfg = ctl(0, 1, 1, 1, 0);
    wr_reg(`EPID_OFS_CTRL, cfg);
    set_pin(1'b0);
    chk_reg("falling ignored", `EPID_OFS_CTRL, cfg);
    set_pin(1'b1);
    chk_reg("rising flag", `EPID_OFS_CTRL, cfg | flg);
    cfg = ctl(1, 1, 1, 1, 0);
    wr_reg(`EPID_OFS_CTRL, cfg | ack);
    settle();
    chk_reg("level holds", `EPID_OFS_CTRL, cfg | flg);
    set_pin(1'b0);
    wr_reg(`EPID_OFS_CTRL, cfg | ack);
    chk_reg("level released", `EPID_OFS_CTRL, cfg);
    be <= 4'he;
    wr_reg(`EPID_OFS_CTRL, 32'h0);
    be <= 4'hf;
    chk_reg("lane off", `EPID_OFS_CTRL, cfg);
    chk_reg("status sticky", `EPID_OFS_IRQ_STATUS, 32'h1);
    wr_reg(`EPID_OFS_IRQ_MASK, 32'h1);
    settle();
    chk("irq unmasked", 32'h1, {31'h0, irq});
    wr_reg(`EPID_OFS_IRQ_MASK, 32'h0);
    settle();
    chk("irq masked", 32'h0, {31'h0, irq});
    wr_reg(`EPID_OFS_IRQ_MASK, 32'h1);
    wr_reg(`EPID_OFS_IRQ_STATUS, 32'h1);
    settle();
    chk("irq cleared", 32'h0, {31'h0, irq});
    chk_reg("status cleared", `EPID_OFS_IRQ_STATUS, 32'h0);
    chk_reg("unmapped read", 4'hc, `EPID_UNMAPPED_DATA);
    wr_reg(4'hc, 32'h0);
    chk_reg("unmapped write", `EPID_OFS_CTRL, cfg);
    // Reset in mid-run returns every register and output to idle
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    chk("wait after reset", 32'h1, {31'h0, wait_req});
    chk("outputs after reset", 32'h0, {29'h0, hw_irq, irq, pu | pd});
    chk_reg("ctrl after reset", `EPID_OFS_CTRL, {24'h0, `EPID_CTRL_RESET});
    chk_reg("status after reset", `EPID_OFS_IRQ_STATUS, 32'h0);
    chk_reg("mask after reset", `EPID_OFS_IRQ_MASK, 32'h0);
    tally_and_finish();
  end
endmodule : epid_top_tb
